// ---- core/adc_conversion_timing.v ----
`timescale 1ns/100ps
`default_nettype none
`include "adc_timing_defs.vh"
module adc_conversion_timing #(
  parameter CAL_BC = `CAL_MIN_BC
) (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Control fields
  input wire [1:0] basic_clock_divider_select,
  input wire [1:0] sample_time_select,
  input wire post_cal_en,
  input wire res_8bit,
  input wire alt_clock_mode,
  input wire [3:0] alt_clock_div,
  // Conversion request and analog front end
  input wire start,
  input wire cmp_in,
  input wire under_range_pin,
  input wire over_range_pin,
  // Status and result
  output wire busy,
  output reg sampling,
  output reg calibrating,
  output reg result_valid,
  output reg [9:0] result
);
  localparam ST_IDLE = 3'h0;
  localparam ST_SAMPLE = 3'h1;
  localparam ST_CONV = 3'h2;
  localparam ST_LOAD = 3'h3;
  reg [2:0] state_reg;
  reg [6:0] bc_cnt_reg;
  reg [2:0] sys_cnt_reg;
  reg [13:0] cal_cnt_reg;
  reg [9:0] sar_reg;
  reg [1:0] range_s1_reg;
  reg [1:0] range_s2_reg;
  reg cmp_s1_reg;
  reg cmp_s2_reg;
  reg [6:0] sample_bc;
  reg [6:0] conv_bc;
  reg [3:0] alt_cnt_reg;
  reg [2:0] state_next;
  reg [6:0] bc_cnt_next;
  reg [2:0] sys_cnt_next;
  reg [9:0] sar_next;
  reg sampling_next;
  reg result_valid_next;
  reg [9:0] result_next;
  reg [13:0] cal_cnt_next;
  reg calibrating_next;
  reg [6:0] bit_count;
  reg [9:0] load_code;
  wire take;
  wire div_tick;
  wire alt_tick;
  wire tick;
  wire run;
  // A taken start restarts the basic clock, so every conversion has the same phase
  assign take = (state_reg == ST_IDLE) && start;
  assign run = (state_reg != ST_IDLE) || (calibrating && !take);
  assign busy = state_reg != ST_IDLE;
  basic_clock_divider u_div (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(run),
    .basic_clock_divider_select(basic_clock_divider_select),
    .bc_tick(div_tick)
  );
  // Alternative clock control: divide by alt_clock_div + 1
  assign alt_tick = run && (alt_cnt_reg >= alt_clock_div);
  assign tick = alt_clock_mode ? alt_tick : div_tick;
  always @* begin
    case (sample_time_select)
      2'h0: sample_bc = `SAMPLE_BC_0;
      2'h1: sample_bc = `SAMPLE_BC_1;
      2'h2: sample_bc = `SAMPLE_BC_2;
      default: sample_bc = `SAMPLE_BC_3;
    endcase
  end
  always @* begin
    conv_bc = res_8bit ? `CONV8_POST_BC : `CONV10_POST_BC;
    if (!post_cal_en) begin
      conv_bc = conv_bc - `POST_CAL_BC;
    end
  end
  // Bits resolved per conversion
  always @* begin
    if (res_8bit) begin
      bit_count = `RES8_BITS;
    end else begin
      bit_count = `RES10_BITS;
    end
  end
  // Pin inputs pass two flip-flops
  always @(posedge sys_clk) begin
    if (!rstn) begin
      range_s1_reg <= 2'h0;
      range_s2_reg <= 2'h0;
      cmp_s1_reg <= 1'b0;
      cmp_s2_reg <= 1'b0;
    end else begin
      range_s1_reg <= {over_range_pin, under_range_pin};
      range_s2_reg <= range_s1_reg;
      cmp_s1_reg <= cmp_in;
      cmp_s2_reg <= cmp_s1_reg;
    end
  end
  always @(posedge sys_clk) begin
    if (!rstn || !run || alt_tick) begin
      alt_cnt_reg <= 4'h0;
    end else begin
      alt_cnt_reg <= alt_cnt_reg + 4'h1;
    end
  end
  // Reset calibration counts idle basic ticks only, so conversions lengthen it
  always @* begin
    calibrating_next = calibrating;
    cal_cnt_next = cal_cnt_reg;
    if (calibrating && tick && state_reg == ST_IDLE) begin
      cal_cnt_next = cal_cnt_reg + 14'h1;
      if (cal_cnt_reg == CAL_BC[13:0] - 14'h1) begin
        calibrating_next = 1'b0;
      end
    end
  end
  always @(posedge sys_clk) begin
    if (!rstn) begin
      calibrating <= 1'b1;
      cal_cnt_reg <= 14'h0;
    end else begin
      calibrating <= calibrating_next;
      cal_cnt_reg <= cal_cnt_next;
    end
  end
  // Out-of-range inputs clamp to the end codes; under range wins
  always @* begin
    if (range_s2_reg[0]) begin
      load_code = `CODE_ZERO;
    end else if (range_s2_reg[1]) begin
      load_code = `CODE_FULL;
    end else if (res_8bit) begin
      load_code = {sar_reg[7:0], 2'h0};
    end else begin
      load_code = sar_reg;
    end
  end
  // Sequencer: sample, resolve bits, load
  always @* begin
    state_next = state_reg;
    bc_cnt_next = bc_cnt_reg;
    sys_cnt_next = sys_cnt_reg;
    sar_next = sar_reg;
    sampling_next = sampling;
    result_valid_next = 1'b0;
    result_next = result;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_SAMPLE;
          bc_cnt_next = 7'h0;
          sampling_next = 1'b1;
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          if (bc_cnt_reg == sample_bc - 7'h1) begin
            state_next = ST_CONV;
            bc_cnt_next = 7'h0;
            sampling_next = 1'b0;
            sar_next = 10'h0;
          end else begin
            bc_cnt_next = bc_cnt_reg + 7'h1;
          end
        end
      end
      ST_CONV: begin
        if (tick) begin
          if (bc_cnt_reg < bit_count) begin
            sar_next = {sar_reg[8:0], cmp_s2_reg};
          end
          if (bc_cnt_reg == conv_bc - 7'h1) begin
            state_next = ST_LOAD;
            sys_cnt_next = 3'h0;
          end else begin
            bc_cnt_next = bc_cnt_reg + 7'h1;
          end
        end
      end
      ST_LOAD: begin
        if (sys_cnt_reg == `LOAD_SYS_CYCLES - 3'h1) begin
          state_next = ST_IDLE;
          result_valid_next = 1'b1;
          result_next = load_code;
        end else begin
          sys_cnt_next = sys_cnt_reg + 3'h1;
        end
      end
      default: begin
        state_next = ST_IDLE;
        sampling_next = 1'b0;
      end
    endcase
  end
  // Sequencer registers
  always @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      bc_cnt_reg <= 7'h0;
      sys_cnt_reg <= 3'h0;
      sar_reg <= 10'h0;
      sampling <= 1'b0;
      result_valid <= 1'b0;
      result <= `CODE_ZERO;
    end else begin
      state_reg <= state_next;
      bc_cnt_reg <= bc_cnt_next;
      sys_cnt_reg <= sys_cnt_next;
      sar_reg <= sar_next;
      sampling <= sampling_next;
      result_valid <= result_valid_next;
      result <= result_next;
    end
  end
endmodule
`default_nettype wire

// ---- core/adc_timing_defs.vh ----
// Contract
// - In compatibility mode the basic clock is the system clock divided by 4, 2, 16 or 8 for select codes 00, 01, 10, 11.
// - The sample duration is 8, 16, 32 or 64 basic-clock periods for sample select codes 00 to 11.
// - A 10-bit conversion takes 52 basic periods with post-calibration or 40 without, plus sample time, plus 6 system clocks to load the result.
// - Turning post-calibration off shortens any conversion by exactly 12 basic-clock periods.
// - Inputs below reference ground give code 0x000 and inputs above reference supply give 0x3ff.
// - Conversions requested during reset calibration are served and lengthen the calibration.
// - The divider and sample encodings apply in compatibility mode only; an alternative input clock control is selectable. The code uses sample codes in both.
// - The converter runs on the system clock, which equals the CPU clock.
// - After reset a calibration sequence of 484 to 11696 basic-clock periods runs.
`ifndef ADC_TIMING_DEFS_VH
`define ADC_TIMING_DEFS_VH
`define SYS_CLK_MHZ 20
`define DIV_CODE_BY4 2'h0
`define DIV_CODE_BY2 2'h1
`define DIV_CODE_BY16 2'h2
`define DIV_CODE_BY8 2'h3
`define SAMPLE_BC_0 7'h08
`define SAMPLE_BC_1 7'h10
`define SAMPLE_BC_2 7'h20
`define SAMPLE_BC_3 7'h40
`define CONV10_POST_BC 7'h34
`define CONV8_POST_BC 7'h2c
`define RES8_BITS 7'h08
`define RES10_BITS 7'h0a
`define POST_CAL_BC 7'h0c
`define LOAD_SYS_CYCLES 3'h6
`define CAL_MIN_BC 484
`define CAL_MAX_BC 11696
`define CODE_ZERO 10'h000
`define CODE_FULL 10'h3ff
`endif

// ---- core/basic_clock_divider.v ----
`timescale 1ns/100ps
`default_nettype none
`include "adc_timing_defs.vh"
module basic_clock_divider (
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Control
  input wire run,
  input wire [1:0] basic_clock_divider_select,
  // Basic clock enable
  output wire bc_tick
);
  reg [3:0] cnt_reg;
  reg [3:0] cnt_next;
  reg [3:0] last;
  always @* begin
    case (basic_clock_divider_select)
      `DIV_CODE_BY4: last = 4'h3;
      `DIV_CODE_BY2: last = 4'h1;
      `DIV_CODE_BY16: last = 4'hf;
      `DIV_CODE_BY8: last = 4'h7;
      default: last = 4'h3;
    endcase
  end
  assign bc_tick = run && (cnt_reg >= last);
  always @* begin
    if (!run || bc_tick) begin
      cnt_next = 4'h0;
    end else begin
      cnt_next = cnt_reg + 4'h1;
    end
  end
  always @(posedge sys_clk) begin
    if (!rstn) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// ---- tb/adc_conversion_timing_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_timing_asserts (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Watched ports
  input wire logic start,
  input wire logic under_range_pin,
  input wire logic over_range_pin,
  input wire logic busy,
  input wire logic sampling,
  input wire logic calibrating,
  input wire logic result_valid,
  input wire logic [9:0] result
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_pulse; result_valid |=> !result_valid; endproperty
  a_pulse: assert property (p_pulse) else $error("valid too long");
  property p_done; result_valid |-> !busy; endproperty
  a_done: assert property (p_done) else $error("busy at result");
  property p_take; start && !busy |=> busy && sampling; endproperty
  a_take: assert property (p_take) else $error("start not taken");
  property p_smp; sampling |-> busy; endproperty
  a_smp: assert property (p_smp) else $error("sampling while idle");
  property p_smp8; $rose(sampling) |-> sampling [*8]; endproperty
  a_smp8: assert property (p_smp8) else $error("sample too short");
  property p_hold; $changed(result) |-> result_valid; endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_under; result_valid && $past(under_range_pin, 3) |-> result == 10'h000;
  endproperty
  a_under: assert property (p_under) else $error("under not zero");
  property p_over;
    result_valid && $past(over_range_pin, 3) && !$past(under_range_pin, 3) |-> result == 10'h3ff;
  endproperty
  a_over: assert property (p_over) else $error("over not full");
  property p_cal; calibrating && busy |=> calibrating; endproperty
  a_cal: assert property (p_cal) else $error("calibration ended in conversion");
endmodule
bind adc_conversion_timing adc_conversion_timing_asserts u_chk (.sys_clk, .rstn, .start,
  .under_range_pin, .over_range_pin, .busy, .sampling, .calibrating, .result_valid, .result);
`default_nettype wire

// ---- tb/analog_source.sv ----
`timescale 1ns/100ps
`default_nettype none
module analog_source (
  // Zone: 0 below ground, 1 low, 2 high, 3 above supply
  input wire logic [1:0] zone,
  // Comparator and range pins
  output logic cmp_in,
  output logic under_range_pin,
  output logic over_range_pin
);
  // Comparator opposes the range pins so forcing is visible
  assign cmp_in = ~zone[0];
  assign under_range_pin = (zone == 2'h0);
  assign over_range_pin = (zone == 2'h3);
endmodule
`default_nettype wire

// ---- tb/tb_adc_conversion_timing.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_adc_conversion_timing;
  logic sys_clk, rstn, start, post, r8, alt;
  logic [1:0] dsel, ssel, zone;
  logic [3:0] adiv;
  wire cmp, und, ovr, busy, smp, cal, rv;
  wire [9:0] result;
  int bad_count, num_checks, cyc, ref_off, d, lon, loff;
  adc_conversion_timing #(.CAL_BC(4)) dut (.sys_clk, .rstn, .basic_clock_divider_select(dsel),
    .sample_time_select(ssel), .post_cal_en(post), .res_8bit(r8), .alt_clock_mode(alt),
    .alt_clock_div(adiv), .start, .cmp_in(cmp), .under_range_pin(und), .over_range_pin(ovr),
    .busy, .sampling(smp), .calibrating(cal), .result_valid(rv), .result);
  analog_source src (.zone, .cmp_in(cmp), .under_range_pin(und), .over_range_pin(ovr));
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s exp %h got %h", n, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic int ratio(logic a, logic [3:0] ad, logic [1:0] ds);
    return a ? ad + 1 : (ds == 2'h0 ? 4 : ds == 2'h1 ? 2 : ds == 2'h2 ? 16 : 8);
  endfunction
  function automatic int core_bc(logic [1:0] s, logic b8, logic pc);
    return (8 << s) + (b8 ? 32 : 40) + (pc ? 12 : 0);
  endfunction
  function automatic logic [15:0] exp_code(logic [1:0] z, logic b8);
    return z < 2'h2 ? 16'h0 : (z == 2'h2 && b8 ? 16'h3fc : 16'h3ff);
  endfunction
  task automatic conv(output int lat);
    @(negedge sys_clk) start = 1;
    @(negedge sys_clk) start = 0;
    lat = 1;
    while (rv !== 1'b1) begin
      @(negedge sys_clk);
      lat++;
    end
  endtask
  initial begin
    sys_clk = 0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    {rstn, start, post, r8, alt, dsel, ssel, zone, adiv} = 0;
    void'($urandom(32'hf775));
    repeat (6) @(negedge sys_clk);
    rstn = 1;
    chk("cal", 1, 16'(cal));
    for (int i = 0; i < 24; i++) begin
      if (i > 0) begin
        {dsel, ssel, r8, zone, adiv} = 11'($urandom);
        alt = (i % 3 == 0);
      end
      // Every choice keeps the basic clock in 1.25 to 20 MHz
      d = ratio(alt, adiv, dsel);
      post = 1;
      conv(lon);
      chk("code", exp_code(zone, r8), 16'(result));
      chk("lat on", 16'(core_bc(ssel, r8, 1) * d + 7), 16'(lon));
      post = 0;
      conv(loff);
      chk("post diff", 16'(12 * d), 16'(lon - loff));
      ref_off = loff - core_bc(ssel, r8, 0) * d;
      chk("lat", 16'(7), 16'(ref_off));
      chk("load", 1, 16'(ref_off >= 6 && ref_off <= 8));
      if (i == 0) begin
        chk("cal kept", 1, 16'(cal));
        repeat (200) @(negedge sys_clk);
        chk("cal end", 0, 16'(cal));
      end
    end
    end_sim();
  end
endmodule
`default_nettype wire
